// ---- hw/pim_mapper.sv ----
`timescale 1ns/1ps
`default_nettype none
// Function
// - Discover terminals at power-up, map all channels.
// - Separate input and output mapping groups.
// - Byte channels first ascending, then bit channels.
// - I_TERM_BYTES image bits per digital channel.
// - Separate output bit memory, driven on the next clock.
// - Analog values two-byte signed two's complement.
// - Code zero means channel zero point.
// - Full scale 7FFF and 8000, linear.
// - Unused low resolution bits zero, ignored.
// - Control/status byte mapping chosen by master.
// - Analog and special channels word aligned.
// - Special channels like analog, any width.
// - List built per channel, left to right.
// - Whole image exchanged every transfer.
module pim_mapper #(
  parameter int N_TERM = 64,
  parameter int AW = 10
) (
  input wire logic I_CORE_CLK,
  input wire logic I_RESET,
  input wire logic I_DISCOVER,
  input wire logic I_CSB_MAPPED,
  input wire logic [1:0] I_TERM_KIND,
  input wire logic I_TERM_IS_OUT,
  input wire logic [7:0] I_TERM_BYTES,
  output logic [$clog2(N_TERM)-1:0] O_TERM_SEL,
  output logic O_BUSY,
  output logic O_MAP_VALID,
  output logic O_MAP_WE,
  output logic O_MAP_IS_OUT,
  output logic O_MAP_IS_BIT,
  output logic [AW+2:0] O_MAP_BITADDR,
  output logic [$clog2(N_TERM)-1:0] O_MAP_TERM,
  output logic [AW-1:0] O_IN_SIZE,
  output logic [AW-1:0] O_OUT_SIZE,
  input wire logic I_XFER_START,
  output logic O_XFER_ALL,
  input wire logic [15:0] I_ANA_RAW,
  input wire logic [3:0] I_ANA_RES,
  output logic [15:0] O_ANA_CODE,
  input wire logic I_DOUT_WE,
  input wire logic [7:0] I_DOUT_IDX,
  input wire logic I_DOUT_BIT,
  output logic [255:0] O_DOUT
);
  localparam int TW = $clog2(N_TERM);
  initial begin
    if (N_TERM < 2 || N_TERM > 256 || AW < 4 || AW > 16) begin
      $error("pim_mapper: unsupported parameters");
    end
  end

  typedef struct packed {
    pim_pkg::pim_state_e st;
    logic [TW-1:0] slot;
    logic [AW-1:0] in_ptr;
    logic [AW-1:0] out_ptr;
    logic [AW+2:0] in_bit;
    logic [AW+2:0] out_bit;
    logic valid;
    logic we;
    logic is_out;
    logic is_bit;
    logic [AW+2:0] addr;
    logic [TW-1:0] term;
    logic xfer;
    logic [255:0] dout;
    logic [15:0] ana;
  } pim_s;

  pim_s r;
  pim_s next_r;
  logic [15:0] ana_fmt;
  logic [AW-1:0] span;
  logic [AW-1:0] aligned;

  pim_ana_fmt u_fmt (
    .i_raw(I_ANA_RAW),
    .i_res(I_ANA_RES),
    .o_val(ana_fmt)
  );

  pim_map_mem #(.DEPTH(N_TERM), .WIDTH(AW+3)) u_mem (
    .i_clk(I_CORE_CLK),
    .i_we(r.we),
    .i_waddr(r.term),
    .i_wdata(r.addr),
    .i_raddr(O_TERM_SEL),
    .o_rdata()
  );

  function automatic logic [AW-1:0] word_align(input logic [AW-1:0] a);
    word_align = a + AW'(a[0]);
  endfunction : word_align

  always_comb begin
    next_r = r;
    next_r.we = 1'b0;
    next_r.xfer = 1'b0;
    span = AW'(I_TERM_BYTES);
    aligned = '0;
    if (I_DOUT_WE) begin
      next_r.dout[I_DOUT_IDX] = I_DOUT_BIT;
    end
    next_r.ana = ana_fmt;
    if (I_XFER_START) begin
      next_r.xfer = r.valid;
    end
    case (r.st)
      pim_pkg::PIM_IDLE: begin
        if (I_DISCOVER) begin
          next_r.st = pim_pkg::PIM_SCAN_BYTE;
          next_r.valid = 1'b0;
          next_r.slot = '0;
          next_r.in_ptr = AW'(pim_pkg::ADDR_START);
          next_r.out_ptr = AW'(pim_pkg::ADDR_START);
        end
      end
      pim_pkg::PIM_SCAN_BYTE: begin
        // Byte channels walk first so bit data lands above them.
        if (I_TERM_KIND == pim_pkg::KIND_ANA || I_TERM_KIND == pim_pkg::KIND_SPC) begin
          if (I_TERM_KIND == pim_pkg::KIND_ANA) begin
            span = AW'(pim_pkg::ANA_BYTES) + AW'(I_CSB_MAPPED);
          end
          aligned = word_align(I_TERM_IS_OUT ? r.out_ptr : r.in_ptr);
          next_r.we = 1'b1;
          next_r.is_out = I_TERM_IS_OUT;
          next_r.is_bit = 1'b0;
          next_r.term = r.slot;
          next_r.addr = {aligned, 3'h0};
          if (I_TERM_IS_OUT) begin
            next_r.out_ptr = aligned + span;
          end else begin
            next_r.in_ptr = aligned + span;
          end
        end
        next_r.slot = r.slot + 1'b1;
        if (r.slot == TW'(N_TERM - 1) || I_TERM_KIND == pim_pkg::KIND_NONE) begin
          next_r.st = pim_pkg::PIM_SCAN_BIT;
          next_r.slot = '0;
          // The last slot may have just advanced a pointer, so take the updated one.
          next_r.in_bit = {next_r.in_ptr, 3'h0};
          next_r.out_bit = {next_r.out_ptr, 3'h0};
        end
      end
      pim_pkg::PIM_SCAN_BIT: begin
        if (I_TERM_KIND == pim_pkg::KIND_DIG) begin
          next_r.we = 1'b1;
          next_r.is_out = I_TERM_IS_OUT;
          next_r.is_bit = 1'b1;
          next_r.term = r.slot;
          next_r.addr = I_TERM_IS_OUT ? r.out_bit : r.in_bit;
          if (I_TERM_IS_OUT) begin
            next_r.out_bit = r.out_bit + (AW+3)'(I_TERM_BYTES);
          end else begin
            next_r.in_bit = r.in_bit + (AW+3)'(I_TERM_BYTES);
          end
        end
        next_r.slot = r.slot + 1'b1;
        if (r.slot == TW'(N_TERM - 1) || I_TERM_KIND == pim_pkg::KIND_NONE) begin
          next_r.st = pim_pkg::PIM_DONE;
        end
      end
      pim_pkg::PIM_DONE: begin
        next_r.valid = 1'b1;
        next_r.st = pim_pkg::PIM_IDLE;
      end
      default: begin
        next_r.st = pim_pkg::PIM_IDLE;
      end
    endcase
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (I_RESET) begin
      r <= '0;
      r.st <= pim_pkg::PIM_SCAN_BYTE;
    end else begin
      r <= next_r;
    end
  end

  always_comb begin
    O_TERM_SEL = r.slot;
    O_BUSY = (r.st != pim_pkg::PIM_IDLE);
    O_MAP_VALID = r.valid;
    O_MAP_WE = r.we;
    O_MAP_IS_OUT = r.is_out;
    O_MAP_IS_BIT = r.is_bit;
    O_MAP_BITADDR = r.addr;
    O_MAP_TERM = r.term;
    O_IN_SIZE = r.in_bit[AW+2:3] + AW'(|r.in_bit[2:0]);
    O_OUT_SIZE = r.out_bit[AW+2:3] + AW'(|r.out_bit[2:0]);
    O_XFER_ALL = r.xfer;
    O_ANA_CODE = r.ana;
    O_DOUT = r.dout;
  end

  // Assertions.
  property p_word_al;
    @(posedge I_CORE_CLK) disable iff (I_RESET)
      (O_MAP_WE && !O_MAP_IS_BIT) |-> (O_MAP_BITADDR[3:0] == 4'h0);
  endproperty
  word_align_a: assert property (p_word_al) else $error("byte channel not word aligned");
  dout_now_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RESET)
    I_DOUT_WE |=> O_DOUT[$past(I_DOUT_IDX)] == $past(I_DOUT_BIT))
    else $error("output bit not driven next cycle");
  bit_after_byte_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RESET)
    (O_MAP_WE && O_MAP_IS_BIT) |-> !(r.st == pim_pkg::PIM_SCAN_BYTE))
    else $error("bit channel placed during byte pass");
  res_zero_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RESET)
    (I_ANA_RES == 4'hc) |=> (O_ANA_CODE[2:0] == 3'h0))
    else $error("unused low bits not zero");
  full_scale_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RESET)
    (I_ANA_RAW == pim_pkg::ANA_POS_FULL && I_ANA_RES == 4'hf) |=>
      (O_ANA_CODE == pim_pkg::ANA_POS_FULL))
    else $error("positive full scale altered");
  zero_code_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RESET)
    (I_ANA_RAW == pim_pkg::ANA_ZERO) |=> (O_ANA_CODE == pim_pkg::ANA_ZERO))
    else $error("zero point altered");
  start_zero_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RESET)
    (r.st == pim_pkg::PIM_IDLE && I_DISCOVER) |=> (r.in_ptr == '0 && r.out_ptr == '0))
    else $error("area does not restart at zero");
  slot_step_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RESET)
    (r.st == pim_pkg::PIM_SCAN_BYTE && $past(r.st) == pim_pkg::PIM_SCAN_BYTE &&
      !$past(I_RESET)) |->
      (r.slot == $past(r.slot) + 1'b1))
    else $error("scan not left to right");
  xfer_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RESET)
    (I_XFER_START && O_MAP_VALID) |=> O_XFER_ALL)
    else $error("transfer not granted");
  size_hold_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RESET)
    (r.st == pim_pkg::PIM_IDLE && !I_DISCOVER) |=> $stable(O_IN_SIZE))
    else $error("input area resized without rediscovery");
  scan_done_c: cover property (@(posedge I_CORE_CLK) r.st == pim_pkg::PIM_DONE);
  ana_map_c: cover property (@(posedge I_CORE_CLK) O_MAP_WE && !O_MAP_IS_BIT);
  dig_map_c: cover property (@(posedge I_CORE_CLK) O_MAP_WE && O_MAP_IS_BIT && O_MAP_IS_OUT);
endmodule : pim_mapper
`default_nettype wire

// ---- hw/pim_pkg.sv ----
package pim_pkg;
  // Terminal kinds reported by discovery.
  localparam logic [1:0] KIND_DIG = 2'h0;
  localparam logic [1:0] KIND_ANA = 2'h1;
  localparam logic [1:0] KIND_SPC = 2'h2;
  localparam logic [1:0] KIND_NONE = 2'h3;
  // Analog code limits and full resolution.
  localparam logic [15:0] ANA_POS_FULL = 16'h7fff;
  localparam logic [15:0] ANA_NEG_FULL = 16'h8000;
  localparam logic [15:0] ANA_ZERO = 16'h0000;
  localparam int ANA_BYTES = 2;
  localparam int ANA_FULL_RES = 15;
  localparam int ADDR_START = 0;
  typedef enum logic [2:0] {
    PIM_IDLE,
    PIM_SCAN_BYTE,
    PIM_SCAN_BIT,
    PIM_DONE
  } pim_state_e;
endpackage : pim_pkg

// ---- hw/pim_map_mem.sv ----
`timescale 1ns/1ps
`default_nettype none
module pim_map_mem #(
  parameter int DEPTH = 64,
  parameter int WIDTH = 12
) (
  input wire logic i_clk,
  input wire logic i_we,
  input wire logic [$clog2(DEPTH)-1:0] i_waddr,
  input wire logic [WIDTH-1:0] i_wdata,
  input wire logic [$clog2(DEPTH)-1:0] i_raddr,
  output logic [WIDTH-1:0] o_rdata
);
  // Assignment list storage; read data is registered.
  logic [WIDTH-1:0] mem [DEPTH];
  always_ff @(posedge i_clk) begin
    if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
    o_rdata <= mem[i_raddr];
  end
endmodule : pim_map_mem
`default_nettype wire

// ---- hw/pim_ana_fmt.sv ----
`timescale 1ns/1ps
`default_nettype none
module pim_ana_fmt (
  input wire logic [15:0] i_raw,
  input wire logic [3:0] i_res,
  output logic [15:0] o_val
);
  // Clears bits below the channel resolution; used only on the I_ANA_RAW to O_ANA_CODE path.
  logic [15:0] mask;
  always_comb begin
    mask = 16'hffff << (4'(pim_pkg::ANA_FULL_RES) - i_res);
    o_val = i_raw & mask;
  end
endmodule : pim_ana_fmt
`default_nettype wire

// ---- dv/pim_term_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module pim_term_model (
  input wire logic [3:0] i_sel,
  output logic [1:0] o_kind,
  output logic o_is_out,
  output logic [7:0] o_bytes
);
  logic [1:0] kind [16];
  logic is_out [16];
  logic [7:0] bytes [16];
  // The chain answers at once for the selected slot; kind none marks its end.
  assign o_kind = kind[i_sel];
  assign o_is_out = is_out[i_sel];
  assign o_bytes = bytes[i_sel];
endmodule : pim_term_model
`default_nettype wire

// ---- dv/process_image_mapper_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module process_image_mapper_tb;
  logic clk = 0, rst = 1, disc = 0, csb = 0, xs = 0, dwe = 0, dbit = 0;
  logic [1:0] kind;
  logic is_out;
  logic [7:0] tbytes, didx = 0;
  logic [15:0] raw = 0;
  logic [3:0] res = 4'hf, sel, mterm;
  logic busy, valid, we, m_out, m_bit, xall;
  logic [12:0] baddr;
  logic [9:0] in_sz, out_sz;
  logic [15:0] code;
  logic [255:0] dout;
  logic [18:0] exp_q [$];
  int fail_count = 0, total_checks = 0, exp_sz [2], nslots;
  always #12.5 clk = ~clk;
  pim_term_model term (.i_sel(sel), .o_kind(kind), .o_is_out(is_out), .o_bytes(tbytes));
  pim_mapper #(.N_TERM(16), .AW(10)) dut (.I_CORE_CLK(clk), .I_RESET(rst), .I_DISCOVER(disc),
    .I_CSB_MAPPED(csb), .I_TERM_KIND(kind), .I_TERM_IS_OUT(is_out), .I_TERM_BYTES(tbytes),
    .O_TERM_SEL(sel), .O_BUSY(busy), .O_MAP_VALID(valid), .O_MAP_WE(we),
    .O_MAP_IS_OUT(m_out), .O_MAP_IS_BIT(m_bit), .O_MAP_BITADDR(baddr), .O_MAP_TERM(mterm),
    .O_IN_SIZE(in_sz), .O_OUT_SIZE(out_sz), .I_XFER_START(xs), .O_XFER_ALL(xall),
    .I_ANA_RAW(raw), .I_ANA_RES(res), .O_ANA_CODE(code), .I_DOUT_WE(dwe), .I_DOUT_IDX(didx),
    .I_DOUT_BIT(dbit), .O_DOUT(dout));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic report_and_stop;
    if (fail_count == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : report_and_stop
  task automatic step;
    @(posedge clk);
    #2;
  endtask : step
  // Draws a chain and works out the entries that the scan must emit, in order.
  task automatic cfg;
    int b [2], n [2], k, o;
    nslots = 1 + $urandom % 16;
    b = '{0, 0};
    n = '{0, 0};
    exp_q.delete();
    for (k = 0; k < 16; k++) begin
      term.kind[k] = k < nslots ? 2'($urandom % 3) : pim_pkg::KIND_NONE;
      term.is_out[k] = 1'($urandom);
      term.bytes[k] = term.kind[k] == pim_pkg::KIND_DIG ? 8'(1 + $urandom % 8) : 8'(1 + $urandom % 6);
    end
    for (k = 0; k < nslots; k++) if (term.kind[k] != pim_pkg::KIND_DIG) begin
      o = term.is_out[k];
      b[o] += b[o] % 2;
      exp_q.push_back({1'(o), 1'b0, 13'(b[o] * 8), 4'(k)});
      b[o] += term.kind[k] == pim_pkg::KIND_ANA ? pim_pkg::ANA_BYTES + csb : term.bytes[k];
    end
    for (k = 0; k < nslots; k++) if (term.kind[k] == pim_pkg::KIND_DIG) begin
      o = term.is_out[k];
      exp_q.push_back({1'(o), 1'b1, 13'(b[o] * 8 + n[o]), 4'(k)});
      n[o] += term.bytes[k];
    end
    for (k = 0; k < 2; k++) exp_sz[k] = b[k] + (n[k] + 7) / 8;
  endtask : cfg
  task automatic finish_map;
    int i;
    for (i = 0; i < 300 && valid !== 1'b1; i++) step();
    chk(32'(valid), 32'h1);
    chk(32'(busy), 32'h0);
    chk(32'(in_sz), exp_sz[0]);
    chk(32'(out_sz), exp_sz[1]);
    chk(exp_q.size(), 0);
  endtask : finish_map
  always @(negedge clk) if (!rst && we === 1'b1) begin
    if (exp_q.size() == 0) chk(32'hffffffff, 32'h0);
    else chk(32'({m_out, m_bit, baddr, mterm}), 32'(exp_q.pop_front()));
  end
  initial begin
    #(25ns * 30000);
    fail_count++;
    report_and_stop();
  end
  initial begin
    int r, i;
    void'($urandom(32'h886f6795));
    cfg();
    repeat (20) @(posedge clk);
    #2 rst = 0;
    finish_map();
    for (r = 0; r < 8; r++) begin
      csb = 1'(r);
      cfg();
      disc = 1;
      step();
      disc = 0;
      chk(32'(busy), 32'h1);
      step();
      // A second request in mid-scan must not restart the list.
      if (nslots > 8) disc = 1;
      step();
      disc = 0;
      finish_map();
      xs = 1;
      step();
      xs = 0;
      chk(32'(xall), 32'h1);
      step();
      chk(32'(xall), 32'h0);
      for (i = 0; i < 6; i++) begin
        raw = i == 0 ? pim_pkg::ANA_ZERO : i == 1 ? pim_pkg::ANA_POS_FULL : i == 2 ? pim_pkg::ANA_NEG_FULL : 16'($urandom);
        res = i < 3 ? 4'hf : 4'(1 + $urandom % 15);
        step();
        chk(32'(code), 32'(raw & (16'hffff << (15 - res))));
        didx = 8'($urandom);
        dbit = 1'($urandom);
        dwe = 1;
        step();
        dwe = 0;
        chk(32'(dout[didx]), 32'(dbit));
      end
    end
    report_and_stop();
  end
endmodule : process_image_mapper_tb
`default_nettype wire
